//--- shared/smc_map.vh
// constants for the operating-mode controller: offsets, fields, timing
// assumes a 20 MHz system clock and a one-cycle register port
`ifndef SMC_MAP_VH
`define SMC_MAP_VH
// register indices
`define SMC_ADDR_CTRL   2'h0
`define SMC_ADDR_STAT   2'h1
// control register fields
`define SMC_CTRL_RST    12'h000
`define SMC_F_MSEL_HI   1
`define SMC_F_MSEL_LO   0
`define SMC_F_CAN_LP    2
`define SMC_F_LIN1_LP   3
`define SMC_F_LIN2_LP   4
`define SMC_F_WD_SEL    5
`define SMC_F_RST_LONG  6
`define SMC_F_WEN_CAN   7
`define SMC_F_WEN_LIN   8
`define SMC_F_WEN_LOC   9
`define SMC_F_WB_SLOW   10
`define SMC_F_LIMP      11
// mode-select encodings
`define SMC_MSEL_STBY   2'b00
`define SMC_MSEL_SLEEP  2'b01
`define SMC_MSEL_NRM_LO 2'b10
`define SMC_MSEL_NRM_HI 2'b11
// transceiver power states
`define SMC_XC_OFF      2'b00
`define SMC_XC_LOWP     2'b01
`define SMC_XC_ACT      2'b10
// watchdog modes
`define SMC_WD_OFF      2'b00
`define SMC_WD_TOUT     2'b01
`define SMC_WD_WIN      2'b10
// timing, in microseconds, and clock rate
`define SMC_CLK_MHZ     20
`define SMC_T_RST_S_US  3600
`define SMC_T_RST_L_US  20000
`define SMC_T_WB16_US   16000
`define SMC_T_WB64_US   64000
`define SMC_T_WBON_US   1000
`endif

//--- logic/smc_mode_ctrl.v
// operating-mode state machine with control/status registers
// assumes synchronous pins, one-cycle register strobes, 20 MHz clock
`include "smc_map.vh"

module smc_mode_ctrl #(
  parameter [21:0] CNT_RST_S = `SMC_T_RST_S_US * `SMC_CLK_MHZ,
  parameter [21:0] CNT_RST_L = `SMC_T_RST_L_US * `SMC_CLK_MHZ,
  parameter [21:0] CNT_WB16  = `SMC_T_WB16_US * `SMC_CLK_MHZ,
  parameter [21:0] CNT_WB64  = `SMC_T_WB64_US * `SMC_CLK_MHZ,
  parameter [21:0] CNT_WBON  = `SMC_T_WBON_US * `SMC_CLK_MHZ
) (
  // clock and reset
  input  wire        CLK_SYS_I,
  input  wire        RST_I,
  // register port
  input  wire [1:0]  ADDR_I,
  input  wire [11:0] WDATA_I,
  input  wire        WR_I,
  input  wire        RD_I,
  output reg  [11:0] RDATA_O,
  // battery and temperature detectors
  input  wire        BAT_POFF_I,
  input  wire        BAT_PON_I,
  input  wire        OT_ACT_I,
  input  wire        OT_REL_I,
  // wake and system status
  input  wire        CAN_WAKE_I,
  input  wire        LIN1_WAKE_I,
  input  wire        LIN2_WAKE_I,
  input  wire        LOCAL_WAKE_INPUT_1_I,
  input  wire        LOCAL_WAKE_INPUT_2_I,
  input  wire        WAKE_PENDING_I,
  input  wire        INTERRUPT_OUT_N_I,
  input  wire        SYS_RESET_REQ_I,
  input  wire        WATCHDOG_DISABLE_PIN_I,
  // bidirectional reset line, open drain
  input  wire        BIDIR_RESET_LINE_N_I,
  output reg         BIDIR_RESET_LINE_N_O,
  output reg         BIDIR_RESET_LINE_N_OE_O,
  // power and transceiver controls
  output reg         MAIN_REGULATOR_EN_O,
  output reg         CAN_REGULATOR_EN_O,
  output reg  [1:0]  CAN_XCVR_O,
  output reg  [1:0]  LIN1_XCVR_O,
  output reg  [1:0]  LIN2_XCVR_O,
  output reg  [1:0]  WD_MODE_O,
  output reg         LIMP_HOME_N_O,
  output reg         WAKE_BIAS_DRIVE_O,
  output reg  [4:0]  MODE_O
);

  // one-hot operating modes
  localparam [4:0] ST_OFF   = 5'h01;
  localparam [4:0] ST_STBY  = 5'h02;
  localparam [4:0] ST_NORM  = 5'h04;
  localparam [4:0] ST_SLEEP = 5'h08;
  localparam [4:0] ST_OT    = 5'h10;

  reg  [4:0]  mode_q;
  reg  [4:0]  mode_d;
  reg  [11:0] ctrl_q;
  reg  [11:0] ctrl_d;
  reg  [3:0]  meta_q;
  reg  [3:0]  sync_q;
  reg  [21:0] rst_cnt_q;
  reg  [21:0] rst_cnt_d;
  reg  [21:0] wb_cnt_q;
  reg         rst_go;
  reg         rst_sh;
  reg         hw_clr;
  reg         drive_low;
  wire        poff_s;
  wire        pon_s;
  wire        ota_s;
  wire        otr_s;
  wire        wr_ctrl;
  wire [1:0]  wsel;
  wire        any_wake;
  wire        wake_src;
  wire        sleep_ok;
  wire        sys_rst;
  wire        wd_on;
  wire [21:0] wb_per;

  // two-stage synchronisers for detector flags
  always @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      meta_q <= 4'h0;
      sync_q <= 4'h0;
    end else begin
      meta_q <= {OT_REL_I, OT_ACT_I, BAT_PON_I, BAT_POFF_I};
      sync_q <= meta_q;
    end
  end

  assign poff_s = sync_q[0];
  assign pon_s  = sync_q[1];
  assign ota_s  = sync_q[2];
  assign otr_s  = sync_q[3];

  // decoded requests and entry conditions
  assign wr_ctrl  = WR_I && (ADDR_I == `SMC_ADDR_CTRL);
  assign wsel     = WDATA_I[`SMC_F_MSEL_HI:`SMC_F_MSEL_LO];
  assign wake_src = ctrl_q[`SMC_F_WEN_CAN] | ctrl_q[`SMC_F_WEN_LIN]
                  | ctrl_q[`SMC_F_WEN_LOC];
  assign any_wake = (ctrl_q[`SMC_F_WEN_CAN] & CAN_WAKE_I)
                  | (ctrl_q[`SMC_F_WEN_LIN] & (LIN1_WAKE_I | LIN2_WAKE_I))
                  | (ctrl_q[`SMC_F_WEN_LOC]
                     & (LOCAL_WAKE_INPUT_1_I | LOCAL_WAKE_INPUT_2_I));
  assign sleep_ok = INTERRUPT_OUT_N_I & ~WAKE_PENDING_I & wake_src;
  // reset seen on the line while not driven, or requested internally
  assign sys_rst  = SYS_RESET_REQ_I
                  | (~BIDIR_RESET_LINE_N_I & ~BIDIR_RESET_LINE_N_OE_O);

  // mode transitions
  always @* begin
    mode_d = mode_q;
    rst_go = 1'b0;
    rst_sh = 1'b0;
    hw_clr = 1'b0;
    case (mode_q)
      ST_OFF: begin
        if (pon_s) begin
          mode_d = ST_STBY;
          rst_go = 1'b1;
        end
      end
      ST_STBY: begin
        if (ota_s) begin
          mode_d = ST_OT;
        end else if (wr_ctrl && wsel[1]) begin
          mode_d = ST_NORM;
        end else if (wr_ctrl && wsel == `SMC_MSEL_SLEEP) begin
          if (sleep_ok) begin
            mode_d = ST_SLEEP;
          end else begin
            rst_go = 1'b1;
            rst_sh = 1'b1;
            hw_clr = 1'b1;
          end
        end else if (SYS_RESET_REQ_I) begin
          rst_go = 1'b1;
        end
      end
      ST_NORM: begin
        if (ota_s) begin
          mode_d = ST_OT;
        end else if (sys_rst) begin
          mode_d = ST_STBY;
          rst_go = SYS_RESET_REQ_I;
          hw_clr = 1'b1;
        end else if (wr_ctrl && wsel == `SMC_MSEL_STBY) begin
          mode_d = ST_STBY;
        end else if (wr_ctrl && wsel == `SMC_MSEL_SLEEP) begin
          if (sleep_ok) begin
            mode_d = ST_SLEEP;
          end else begin
            mode_d = ST_STBY;
            rst_go = 1'b1;
            rst_sh = 1'b1;
            hw_clr = 1'b1;
          end
        end
      end
      ST_SLEEP: begin
        if (any_wake) begin
          mode_d = ST_STBY;
          rst_go = 1'b1;
          hw_clr = 1'b1;
        end
      end
      ST_OT: begin
        if (otr_s) begin
          mode_d = ST_STBY;
          rst_go = 1'b1;
        end
      end
      default: begin
        mode_d = ST_OFF;
      end
    endcase
    // power-off overrides every other trigger
    if (poff_s) begin
      mode_d = ST_OFF;
      rst_go = 1'b0;
      hw_clr = 1'b0;
    end
  end

  // control register: software writes, hardware clear/set wins
  always @* begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d = WDATA_I;
    end
    if (hw_clr) begin
      ctrl_d[`SMC_F_MSEL_HI:`SMC_F_MSEL_LO] = `SMC_MSEL_STBY;
    end
    if (mode_d == ST_OT && mode_q != ST_OT) begin
      ctrl_d[`SMC_F_LIMP] = 1'b1;
    end
  end

  // reset pulse length counter
  always @* begin
    rst_cnt_d = rst_cnt_q;
    if (rst_go) begin
      if (rst_sh || !ctrl_q[`SMC_F_RST_LONG]) begin
        rst_cnt_d = CNT_RST_S;
      end else begin
        rst_cnt_d = CNT_RST_L;
      end
    end else if (rst_cnt_q != 22'h0) begin
      rst_cnt_d = rst_cnt_q - 22'h1;
    end
    if (mode_d == ST_OFF) begin
      rst_cnt_d = 22'h0;
    end
  end

  // reset line held low outside the powered modes
  always @* begin
    drive_low = (rst_cnt_d != 22'h0);
    if (mode_d == ST_SLEEP || mode_d == ST_OT || mode_d == ST_OFF) begin
      drive_low = 1'b1;
    end
  end

  // state registers
  always @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      mode_q    <= ST_OFF;
      ctrl_q    <= `SMC_CTRL_RST;
      rst_cnt_q <= 22'h0;
    end else begin
      mode_q    <= mode_d;
      ctrl_q    <= ctrl_d;
      rst_cnt_q <= rst_cnt_d;
    end
  end

  // transceiver power state for a mode and select bit
  function [1:0] smc_xc;
    input [4:0] m;
    input       lp;
    begin
      if (m == ST_NORM) begin
        smc_xc = lp ? `SMC_XC_LOWP : `SMC_XC_ACT;
      end else if (m == ST_STBY || m == ST_SLEEP) begin
        smc_xc = lp ? `SMC_XC_LOWP : `SMC_XC_OFF;
      end else begin
        smc_xc = `SMC_XC_OFF;
      end
    end
  endfunction

  // watchdog enable, cleared by the disable pin
  assign wd_on = ~WATCHDOG_DISABLE_PIN_I;

  // wake bias period counter, runs only in Standby
  assign wb_per = ctrl_q[`SMC_F_WB_SLOW] ? CNT_WB64 : CNT_WB16;

  always @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      wb_cnt_q <= 22'h0;
    end else if (mode_q != ST_STBY || wb_cnt_q >= wb_per - 22'h1) begin
      wb_cnt_q <= 22'h0;
    end else begin
      wb_cnt_q <= wb_cnt_q + 22'h1;
    end
  end

  // registered outputs, taken from next-state values, except wake bias drive from current mode and counter
  always @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      MODE_O                  <= ST_OFF;
      MAIN_REGULATOR_EN_O     <= 1'b0;
      CAN_REGULATOR_EN_O      <= 1'b0;
      CAN_XCVR_O              <= `SMC_XC_OFF;
      LIN1_XCVR_O             <= `SMC_XC_OFF;
      LIN2_XCVR_O             <= `SMC_XC_OFF;
      WD_MODE_O               <= `SMC_WD_OFF;
      LIMP_HOME_N_O           <= 1'b1;
      WAKE_BIAS_DRIVE_O       <= 1'b0;
      BIDIR_RESET_LINE_N_O    <= 1'b0;
      BIDIR_RESET_LINE_N_OE_O <= 1'b1;
    end else begin
      MODE_O <= mode_d;
      // main regulator only in Standby and Normal
      MAIN_REGULATOR_EN_O <= (mode_d == ST_STBY) | (mode_d == ST_NORM);
      // CAN regulator only in Normal with mode 11
      CAN_REGULATOR_EN_O <= (mode_d == ST_NORM)
                            & ctrl_d[`SMC_F_MSEL_LO];
      CAN_XCVR_O  <= smc_xc(mode_d, ctrl_d[`SMC_F_CAN_LP]);
      LIN1_XCVR_O <= smc_xc(mode_d, ctrl_d[`SMC_F_LIN1_LP]);
      LIN2_XCVR_O <= smc_xc(mode_d, ctrl_d[`SMC_F_LIN2_LP]);
      // watchdog mode selection
      if (mode_d == ST_NORM && wd_on) begin
        WD_MODE_O <= ctrl_d[`SMC_F_WD_SEL] ? `SMC_WD_TOUT
                                           : `SMC_WD_WIN;
      end else if (mode_d == ST_STBY && wd_on
                   && !ctrl_d[`SMC_F_WD_SEL]) begin
        WD_MODE_O <= `SMC_WD_TOUT;
      end else begin
        WD_MODE_O <= `SMC_WD_OFF;
      end
      LIMP_HOME_N_O <= ~ctrl_d[`SMC_F_LIMP];
      WAKE_BIAS_DRIVE_O <= (mode_q == ST_STBY)
                           & (wb_cnt_q < CNT_WBON);
      BIDIR_RESET_LINE_N_O    <= 1'b0;
      BIDIR_RESET_LINE_N_OE_O <= drive_low;
    end
  end

  // read data, valid the cycle after the read strobe
  always @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      RDATA_O <= 12'h000;
    end else if (RD_I && ADDR_I == `SMC_ADDR_CTRL) begin
      RDATA_O <= ctrl_q;
    end else if (RD_I && ADDR_I == `SMC_ADDR_STAT) begin
      RDATA_O <= {3'h0, ctrl_q[`SMC_F_LIMP], BIDIR_RESET_LINE_N_OE_O,
                  WD_MODE_O, mode_q};
    end else begin
      RDATA_O <= 12'h000;
    end
  end

endmodule // smc_mode_ctrl

//--- test/smc_checker.sv
// checker: outputs against the mode held, and reactions to writes
// assumes binding into smc_mode_ctrl, ports matched by name
module smc_checker (
  // clock, reset, register port
  input wire logic        CLK_SYS_I, RST_I, WR_I,
  input wire logic [1:0]  ADDR_I,
  input wire logic [11:0] WDATA_I,
  // detector and sleep gating
  input wire logic        BAT_POFF_I, WAKE_PENDING_I, INTERRUPT_OUT_N_I,
  // controlled outputs
  input wire logic        MAIN_REGULATOR_EN_O, CAN_REGULATOR_EN_O,
  input wire logic        BIDIR_RESET_LINE_N_OE_O, LIMP_HOME_N_O,
  input wire logic [1:0]  CAN_XCVR_O, LIN1_XCVR_O, LIN2_XCVR_O, WD_MODE_O,
  input wire logic [4:0]  MODE_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  // shorthands for the power picture
  wire logic regs_off = !MAIN_REGULATOR_EN_O && !CAN_REGULATOR_EN_O;
  wire logic xc_off = CAN_XCVR_O == 2'b00 && LIN1_XCVR_O == 2'b00 &&
                      LIN2_XCVR_O == 2'b00;
  wire logic oe = BIDIR_RESET_LINE_N_OE_O;
  wire logic wr0 = WR_I && ADDR_I == 2'h0;

  property p_off;
    MODE_O == 5'h01 |-> regs_off && xc_off && oe;
  endproperty
  a_off: assert property (p_off) else $error("off outputs");
  property p_poff;
    BAT_POFF_I [*3] |=> MODE_O == 5'h01;
  endproperty
  a_poff: assert property (p_poff) else $error("no off");
  property p_stby;
    MODE_O == 5'h02 |-> MAIN_REGULATOR_EN_O && !CAN_REGULATOR_EN_O &&
      CAN_XCVR_O != 2'b10 && WD_MODE_O != 2'b10;
  endproperty
  a_stby: assert property (p_stby) else $error("standby outputs");
  property p_norm;
    MODE_O == 5'h04 |-> MAIN_REGULATOR_EN_O && CAN_XCVR_O != 2'b00 &&
      LIN1_XCVR_O != 2'b00 && LIN2_XCVR_O != 2'b00;
  endproperty
  a_norm: assert property (p_norm) else $error("normal outputs");
  property p_slp;
    MODE_O == 5'h08 |-> regs_off && oe && WD_MODE_O == 2'b00;
  endproperty
  a_slp: assert property (p_slp) else $error("sleep outputs");
  property p_ot;
    MODE_O == 5'h10 |-> regs_off && xc_off && oe && !LIMP_HOME_N_O;
  endproperty
  a_ot: assert property (p_ot) else $error("overtemp outputs");
  property p_go;
    MODE_O == 5'h02 && wr0 && WDATA_I[1] |=> MODE_O == 5'h04 &&
      CAN_REGULATOR_EN_O == $past(WDATA_I[0]);
  endproperty
  a_go: assert property (p_go) else $error("no normal");
  property p_refuse;
    (MODE_O == 5'h02 || MODE_O == 5'h04) && wr0 && WDATA_I[1:0] == 2'b01
      && !(INTERRUPT_OUT_N_I && !WAKE_PENDING_I && |WDATA_I[9:7])
      |=> (MODE_O == 5'h02 && oe) [*8];
  endproperty
  a_refuse: assert property (p_refuse) else $error("bad refusal");
endmodule // smc_checker

bind smc_mode_ctrl smc_checker u_chk (
  .CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .WR_I(WR_I), .ADDR_I(ADDR_I),
  .WDATA_I(WDATA_I), .BAT_POFF_I(BAT_POFF_I),
  .WAKE_PENDING_I(WAKE_PENDING_I), .INTERRUPT_OUT_N_I(INTERRUPT_OUT_N_I),
  .MAIN_REGULATOR_EN_O(MAIN_REGULATOR_EN_O),
  .CAN_REGULATOR_EN_O(CAN_REGULATOR_EN_O),
  .BIDIR_RESET_LINE_N_OE_O(BIDIR_RESET_LINE_N_OE_O),
  .LIMP_HOME_N_O(LIMP_HOME_N_O), .CAN_XCVR_O(CAN_XCVR_O),
  .LIN1_XCVR_O(LIN1_XCVR_O), .LIN2_XCVR_O(LIN2_XCVR_O),
  .WD_MODE_O(WD_MODE_O), .MODE_O(MODE_O));

//--- test/smc_mcu_model.sv
// microcontroller side: reset line pull-up and interrupt pin
// assumes the device only ever pulls the reset line low
module smc_mcu_model (
  input  wire logic oe_i,
  input  wire logic irq_i,
  output wire logic line_n_o,
  output wire logic int_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // released line floats up to the pull-up level
  assign line_n_o = !oe_i;
  // pending interrupt pulls the pin low
  assign int_n_o = !irq_i;
endmodule // smc_mcu_model

//--- test/sbc_operating_mode_controller_tb.sv
// bench for the mode controller: walks all five modes
// assumes the mcu model and checker are compiled beside it
module sbc_operating_mode_controller_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, wr = 0, rd = 0, rd_d = 0, irq = 0, sreq = 0;
  logic poff = 0, pon = 0, ota = 0, otr = 0, cwk = 0, pend = 0;
  logic lw1 = 0, lw2 = 0, lk1 = 0, lk2 = 0, watchdog_disable_pin = 0;
  logic [1:0] addr = 0;
  logic [11:0] wdata = 0;
  logic [2:0] lp;
  logic [5:0] sb, nm;
  logic [19:0] q[$], e;
  wire logic [11:0] rdata;
  wire logic [4:0] mode;
  wire logic [1:0] cx, l1, l2, wdm;
  wire logic mr, cr, oe, rst_o, limp_n, wb, line_n, int_n;
  int n_fail = 0, n_tests = 0, cyc = 0, nwb = 0;

  // 20 MHz system clock
  always #25 clk = ~clk;

  smc_mode_ctrl #(.CNT_RST_S(22'd20), .CNT_RST_L(22'd40),
    .CNT_WB16(22'd50), .CNT_WB64(22'd100), .CNT_WBON(22'd5)) dut (
    .CLK_SYS_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .BAT_POFF_I(poff),
    .BAT_PON_I(pon), .OT_ACT_I(ota), .OT_REL_I(otr), .CAN_WAKE_I(cwk),
    .LIN1_WAKE_I(lw1), .LIN2_WAKE_I(lw2),
    .LOCAL_WAKE_INPUT_1_I(lk1), .LOCAL_WAKE_INPUT_2_I(lk2),
    .WAKE_PENDING_I(pend), .INTERRUPT_OUT_N_I(int_n),
    .SYS_RESET_REQ_I(sreq), .WATCHDOG_DISABLE_PIN_I(watchdog_disable_pin),
    .BIDIR_RESET_LINE_N_I(line_n), .BIDIR_RESET_LINE_N_O(rst_o),
    .BIDIR_RESET_LINE_N_OE_O(oe), .MAIN_REGULATOR_EN_O(mr),
    .CAN_REGULATOR_EN_O(cr), .CAN_XCVR_O(cx), .LIN1_XCVR_O(l1),
    .LIN2_XCVR_O(l2), .WD_MODE_O(wdm), .LIMP_HOME_N_O(limp_n),
    .WAKE_BIAS_DRIVE_O(wb), .MODE_O(mode));

  smc_mcu_model mcu (.oe_i(oe), .irq_i(irq), .line_n_o(line_n),
    .int_n_o(int_n));

  // status word plus regulator and transceiver state
  function automatic logic [19:0] ex(logic [4:0] m, logic l, logic o,
      logic [1:0] w, logic [7:0] r);
    return {3'b000, l, o, w, m, r};
  endfunction
  // normal-mode transceiver code for one select bit
  function automatic logic [1:0] xn(logic b);
    return b ? 2'b01 : 2'b10;
  endfunction

  task automatic wt(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr_reg(logic [1:0] a, logic [11:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read strobe, expected answer noted for the watcher
  task automatic chk(logic [1:0] a, logic [19:0] x);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    q.push_back(x);
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task automatic finish_test;
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // watcher: compares each answer with the oldest note; hang guard
  always @(posedge clk) begin
    rd_d <= rd;
    cyc <= cyc + 1;
    if (rd_d) begin
      e = q.pop_front();
      n_tests++;
      if ({rdata, mr, cr, cx, l1, l2} !== e) begin
        n_fail++;
        $display("[ERR] %0t got %h want %h", $time,
          {rdata, mr, cr, cx, l1, l2}, e);
      end
    end
    if (cyc == 1000) begin
      n_fail++;
      finish_test;
    end
  end

  initial begin
    void'($urandom(32'h2c5f));
    lp = 3'($urandom());
    sb = {1'b0, lp[0], 1'b0, lp[1], 1'b0, lp[2]};
    nm = {xn(lp[0]), xn(lp[1]), xn(lp[2])};
    wt(3);
    rst <= 1'b0;
    chk(1, ex(5'h01, 0, 1, 0, 8'h00));
    pon <= 1'b1;
    wt(4);
    pon <= 1'b0;
    chk(1, ex(5'h02, 0, 1, 1, 8'h80));
    wt(25);
    chk(1, ex(5'h02, 0, 0, 1, 8'h80));
    wr_reg(0, {7'h00, lp, 2'b11});
    wt(2);
    chk(1, ex(5'h04, 0, 0, 2, {2'b11, nm}));
    sreq <= 1'b1;
    wt(1);
    sreq <= 1'b0;
    wt(2);
    chk(1, ex(5'h02, 0, 1, 1, {2'b10, sb}));
    wt(25);
    wr_reg(0, {7'h00, lp, 2'b10});
    wr_reg(0, {7'h00, lp, 2'b00});
    // disable pin forces the watchdog off in Standby
    watchdog_disable_pin <= 1'b1;
    wt(2);
    chk(1, ex(5'h02, 0, 0, 0, {2'b10, sb}));
    watchdog_disable_pin <= 1'b0;
    // sleep refused from Normal while the interrupt is pending
    wr_reg(0, {7'h00, lp, 2'b10});
    irq <= 1'b1;
    wr_reg(0, 12'h081);
    irq <= 1'b0;
    wt(2);
    chk(1, ex(5'h02, 0, 1, 1, 8'h80));
    pend <= 1'b1;
    wr_reg(0, 12'h081);
    wt(2);
    chk(1, ex(5'h02, 0, 1, 1, 8'h80));
    chk(0, {12'h080, 8'h80});
    pend <= 1'b0;
    wt(25);
    wr_reg(0, 12'h081);
    wt(2);
    chk(1, ex(5'h08, 0, 1, 0, 8'h00));
    // wakes whose sources are not enabled leave Sleep alone
    lw1 <= 1'b1;
    lw2 <= 1'b1;
    lk1 <= 1'b1;
    lk2 <= 1'b1;
    wt(1);
    lw1 <= 1'b0;
    lw2 <= 1'b0;
    lk1 <= 1'b0;
    lk2 <= 1'b0;
    chk(1, ex(5'h08, 0, 1, 0, 8'h00));
    cwk <= 1'b1;
    wt(1);
    cwk <= 1'b0;
    wt(2);
    chk(1, ex(5'h02, 0, 1, 1, 8'h80));
    chk(0, {12'h080, 8'h80});
    // one full 50-cycle bias period in Standby holds 5 high cycles
    wt(5);
    nwb = 0;
    repeat (50) begin
      @(posedge clk);
      nwb += (wb === 1'b1);
    end
    n_tests++;
    if (nwb != 5) begin
      n_fail++;
      $display("[ERR] %0t wake bias high %0d of 50", $time, nwb);
    end
    ota <= 1'b1;
    wt(4);
    ota <= 1'b0;
    chk(1, ex(5'h10, 1, 1, 0, 8'h00));
    otr <= 1'b1;
    wt(4);
    otr <= 1'b0;
    chk(1, ex(5'h02, 1, 1, 1, 8'h80));
    wr_reg(0, 12'h000);
    poff <= 1'b1;
    ota <= 1'b1;
    wt(4);
    chk(1, ex(5'h01, 0, 1, 0, 8'h00));
    // let the watcher take the last answer before the verdict
    wt(2);
    if (q.size() != 0) begin
      n_fail++;
      $display("[ERR] %0t reads left unanswered", $time);
    end
    finish_test;
  end
endmodule // sbc_operating_mode_controller_tb
